// file: include/scp_defines.svh
// Constants of the serial configuration port: timing, frame layout and
// the controller's own register offsets.
// Assumes a 100 MHz system clock on both ends.
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

// ==========================================================
// Timing
`define SCP_MCLK_NS 10
`define SCP_SCLK_PERIOD_NS 80
`define SCP_SCLK_HALF ((`SCP_SCLK_PERIOD_NS) / (2 * `SCP_MCLK_NS))
`define SCP_UPD_HOLD_NS 100
`define SCP_UPD_CYC \
   (((`SCP_UPD_HOLD_NS) + (`SCP_MCLK_NS) - 1) / (`SCP_MCLK_NS))
`define SCP_ABORT_NS 50
`define SCP_ABORT_CYC \
   (((`SCP_ABORT_NS) + (`SCP_MCLK_NS) - 1) / (`SCP_MCLK_NS))

// ==========================================================
// Frame layout
`define SCP_ADDR_W 5
`define SCP_NUM_REGS 32
`define SCP_REG_BYTES 4
`define SCP_LAST_BYTE 2'h3
`define SCP_FRAME_BITS (8 * (1 + `SCP_REG_BYTES))
`define SCP_INSTR_RD_BIT 7
`define SCP_CFG_ADDR 5'h00
`define SCP_CFG_LSB_BIT 0
`define SCP_CFG_INONLY_BIT 1
`define SCP_REG_RESET 32'h0000_0000
`define SCP_PROF_BASE 5'h0e
`define SCP_PROF_LAST 5'h15

// ==========================================================
// Controller register offsets and fields
`define SCP_H_CMD 8'h00
`define SCP_H_WDATA 8'h04
`define SCP_H_CFG 8'h08
`define SCP_H_RDATA 8'h0c
`define SCP_H_STATUS 8'h10
`define SCP_H_CMD_RD_BIT 7
`define SCP_H_CMD_UPD_BIT 8
`define SCP_H_CMD_ABORT_BIT 9
`define SCP_H_CFG_LSB_BIT 0
`define SCP_H_CFG_3W_BIT 1

`endif

// file: include/scp_if.sv
// Pins of the serial configuration port between host and device.
// Resolves the shared data pin and the data-out pin; an undriven line
// reads high, as with a pull-up.
`timescale 1ns/1ps

interface scp_if;
   logic sclk;
   logic cs_n;
   logic io_reset;
   logic io_update;
   logic [2:0] profile;
   logic host_sdio_o;
   logic host_sdio_oe;
   logic dev_sdio_o;
   logic dev_sdio_oe;
   logic dev_sdo_o;
   logic dev_sdo_oe;
   logic sdio;
   logic serial_data_out_pin;

   // ==========================================================
   // Wire resolution
   assign sdio = host_sdio_oe ? host_sdio_o :
                 (dev_sdio_oe ? dev_sdio_o : 1'b1);
   assign serial_data_out_pin = dev_sdo_oe ? dev_sdo_o : 1'b1;

   modport dev (input sclk, input cs_n, input io_reset, input io_update,
                input profile, input sdio, output dev_sdio_o,
                output dev_sdio_oe, output dev_sdo_o, output dev_sdo_oe);
   modport host (output sclk, output cs_n, output io_reset,
                 output io_update, output profile, output host_sdio_o,
                 output host_sdio_oe, input sdio, input serial_data_out_pin);
endinterface : scp_if

// file: include/scp_pkg.sv
// Types and shared helpers of the serial configuration port.
// Assumes scp_defines.svh is on the include path.
`include "scp_defines.svh"

package scp_pkg;

   // ==========================================================
   // Types
   typedef enum logic {SCP_ST_INSTR, SCP_ST_DATA} scp_dev_state_t;
   typedef enum logic [1:0] {SCP_H_IDLE, SCP_H_XFER, SCP_H_PULSE}
      scp_host_state_t;

   // Byte lane of the k-th data byte: high byte first unless LSB first
   function automatic logic [1:0] scp_lane(input logic [1:0] k,
                                           input logic lsb);
      scp_lane = lsb ? k : (`SCP_LAST_BYTE - k);
   endfunction : scp_lane

   // Next shift value for one serial bit in either order
   function automatic logic [7:0] scp_shift8(input logic [7:0] sh,
                                             input logic b,
                                             input logic lsb);
      scp_shift8 = lsb ? {b, sh[7:1]} : {sh[6:0], b};
   endfunction : scp_shift8

endpackage : scp_pkg

// file: rtl/scp_device.sv
// Device end of the serial configuration port: instruction decode,
// holding buffer, active registers and serial read-back.
// Assumes link pins are asynchronous to mclk_in; all are synchronised.
//
// How it works
// - Instruction byte first, then register data bytes
// - Instruction bit seven high means read
// - Instruction bits six and five ignored
// - Instruction bits four to zero address
// - Data phase carries register width bytes
// - Input bits sampled on serial clock rise
// - Host must send every byte of register
// - Abort input restarts at instruction byte
// - Abort keeps full bytes, drops partial byte
// - After a cycle, eight edges form instruction
// - Writes wait in buffer until update
// - Profile pin change also triggers update
// - Reads return active registers, same length
// - Read bits launched on serial clock fall
// - Host sets profile pins to read profiles
// - Both directions, MSB or LSB first
// - Two-wire or three-wire data pins
// - Control bit zero selects LSB first
// - Control bit one makes shared pin input-only
// - Select high floats outputs, suspends cycle
// - Host holds update high long enough
`timescale 1ns/1ps
`include "scp_defines.svh"

module scp_device (
   input wire logic mclk_in,
   input wire logic resetn_in,
   scp_if.dev link,
   input wire logic [4:0] cfg_addr_in,
   output logic [31:0] cfg_data_out,
   output logic update_out
);
   scp_pkg::scp_dev_state_t state_reg;
   logic [7:0] pins_sync;
   logic s_sclk;
   logic s_csn;
   logic s_sdi;
   logic s_rst;
   logic s_upd;
   logic [2:0] s_prof;
   logic sclk_d_reg;
   logic upd_d_reg;
   logic [2:0] prof_d_reg;
   logic [2:0] bit_cnt_reg;
   logic [1:0] byte_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic rd_reg;
   logic [4:0] addr_reg;
   logic [31:0] buf_reg [`SCP_NUM_REGS];
   logic [31:0] act_reg [`SCP_NUM_REGS];
   logic lsb_first;
   logic sdio_in_only;
   logic active;
   logic rise;
   logic fall;
   logic byte_done;
   logic upd_evt;
   logic [4:0] rd_addr;
   logic [31:0] rd_word;
   logic [4:0] bit_idx;
   logic [4:0] bit_pos;
   logic [1:0] lane;

   // ==========================================================
   // Pin synchronisation and edge detection
   scp_sync #(.W(8)) u_sync (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .d_in({link.sclk, link.cs_n, link.sdio, link.io_reset,
             link.io_update, link.profile}),
      .q_out(pins_sync)
   );

   assign {s_sclk, s_csn, s_sdi, s_rst, s_upd, s_prof} = pins_sync;

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sclk_d_reg <= 1'b0;
         upd_d_reg <= 1'b0;
         prof_d_reg <= 3'h0;
      end else begin
         sclk_d_reg <= s_sclk;
         upd_d_reg <= s_upd;
         prof_d_reg <= s_prof;
      end
   end

   // Serial clock edges only count while selected and not aborted
   assign active = ~s_csn & ~s_rst;
   assign rise = active & s_sclk & ~sclk_d_reg;
   assign fall = active & ~s_sclk & sclk_d_reg;
   assign lsb_first = act_reg[`SCP_CFG_ADDR][`SCP_CFG_LSB_BIT];
   assign sdio_in_only =
      act_reg[`SCP_CFG_ADDR][`SCP_CFG_INONLY_BIT];
   assign shift_next = scp_pkg::scp_shift8(shift_reg, s_sdi,
                                           lsb_first);
   assign byte_done = rise & (bit_cnt_reg == 3'h7);
   // Update on rising strobe edge or any profile pin change
   assign upd_evt = (s_upd & ~upd_d_reg) |
                    (s_prof != prof_d_reg);
   assign lane = scp_pkg::scp_lane(byte_cnt_reg, lsb_first);

   // ==========================================================
   // Cycle sequencer
   // Abort wins over everything; select high just freezes the count.
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_reg <= scp_pkg::SCP_ST_INSTR;
         bit_cnt_reg <= 3'h0;
         byte_cnt_reg <= 2'h0;
         shift_reg <= 8'h00;
         rd_reg <= 1'b0;
         addr_reg <= 5'h00;
      end else if (s_rst) begin
         state_reg <= scp_pkg::SCP_ST_INSTR;
         bit_cnt_reg <= 3'h0;
         byte_cnt_reg <= 2'h0;
      end else if (rise) begin
         shift_reg <= shift_next;
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         if (bit_cnt_reg == 3'h7) begin
            case (state_reg)
               scp_pkg::SCP_ST_INSTR: begin
                  rd_reg <= shift_next[`SCP_INSTR_RD_BIT];
                  addr_reg <= shift_next[4:0];
                  byte_cnt_reg <= 2'h0;
                  state_reg <= scp_pkg::SCP_ST_DATA;
               end
               scp_pkg::SCP_ST_DATA: begin
                  if (byte_cnt_reg == `SCP_LAST_BYTE) begin
                     byte_cnt_reg <= 2'h0;
                     state_reg <= scp_pkg::SCP_ST_INSTR;
                  end else begin
                     byte_cnt_reg <= byte_cnt_reg + 2'h1;
                  end
               end
               default: begin
                  state_reg <= scp_pkg::SCP_ST_INSTR;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Holding buffer: each complete byte lands at once, so an abort
   // keeps the bytes already taken
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         for (int i = 0; i < `SCP_NUM_REGS; i++) begin
            buf_reg[i] <= `SCP_REG_RESET;
         end
      end else if (byte_done && !s_rst && !rd_reg &&
                   state_reg == scp_pkg::SCP_ST_DATA) begin
         buf_reg[addr_reg][lane*8 +: 8] <= shift_next;
      end
   end

   // Active registers copy the whole buffer on an update event
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         for (int i = 0; i < `SCP_NUM_REGS; i++) begin
            act_reg[i] <= `SCP_REG_RESET;
         end
      end else if (upd_evt) begin
         for (int i = 0; i < `SCP_NUM_REGS; i++) begin
            act_reg[i] <= buf_reg[i];
         end
      end
   end

   // ==========================================================
   // Read-back path
   // Profile addresses read the profile picked by the pins
   always_comb begin
      rd_addr = addr_reg;
      if (addr_reg >= `SCP_PROF_BASE && addr_reg <= `SCP_PROF_LAST) begin
         rd_addr = `SCP_PROF_BASE + {2'h0, s_prof};
      end
   end

   assign rd_word = act_reg[rd_addr];
   assign bit_idx = {byte_cnt_reg, bit_cnt_reg};
   // Whole word reversed in LSB-first order, high bit first otherwise
   assign bit_pos = lsb_first ? bit_idx : ~bit_idx;

   // Output drivers: enables only after the first fall of a read data
   // phase, so the host has released the shared pin by then
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         link.dev_sdio_o <= 1'b0;
         link.dev_sdio_oe <= 1'b0;
         link.dev_sdo_o <= 1'b0;
         link.dev_sdo_oe <= 1'b0;
      end else if (!active || state_reg != scp_pkg::SCP_ST_DATA ||
                   !rd_reg) begin
         link.dev_sdio_oe <= 1'b0;
         link.dev_sdo_oe <= 1'b0;
      end else if (fall) begin
         link.dev_sdio_o <= rd_word[bit_pos];
         link.dev_sdo_o <= rd_word[bit_pos];
         link.dev_sdio_oe <= ~sdio_in_only;
         link.dev_sdo_oe <= sdio_in_only;
      end
   end

   // ==========================================================
   // User-side view of the active registers
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cfg_data_out <= 32'h0000_0000;
         update_out <= 1'b0;
      end else begin
         cfg_data_out <= act_reg[cfg_addr_in];
         update_out <= upd_evt;
      end
   end
endmodule : scp_device

// file: rtl/scp_host.sv
// Host end of the serial configuration port: a small register-driven
// controller that runs whole cycles, update strobes and aborts.
// Assumes software matches the bit order and wire mode to the device.
`timescale 1ns/1ps
`include "scp_defines.svh"

module scp_host (
   input wire logic mclk_in,
   input wire logic resetn_in,
   scp_if.host link,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out
);
   localparam int HALF = `SCP_SCLK_HALF;
   localparam int NBITS = `SCP_FRAME_BITS;

   scp_pkg::scp_host_state_t state_reg;
   logic [31:0] wdata_reg;
   logic [31:0] rx_reg;
   logic [4:0] cfg_reg;
   logic [NBITS-1:0] seq_reg;
   logic [5:0] bit_reg;
   logic [3:0] div_reg;
   logic [7:0] cnt_reg;
   logic rdcyc_reg;
   logic [1:0] din_sync;
   logic din;
   logic [7:0] instr;

   // Reverse a whole frame so its top bit goes first
   function automatic logic [NBITS-1:0] rev(input logic [NBITS-1:0] v);
      for (int i = 0; i < NBITS; i++) begin
         rev[i] = v[NBITS-1-i];
      end
   endfunction : rev

   // ==========================================================
   // Returning data pins
   scp_sync #(.W(2)) u_sync (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .d_in({link.sdio, link.serial_data_out_pin}),
      .q_out(din_sync)
   );

   assign din = cfg_reg[`SCP_H_CFG_3W_BIT] ? din_sync[0] : din_sync[1];
   // Spare bits six and five go out as written, so software can
   // show that the device pays no heed to them
   assign instr = wdata_in[7:0];

   // ==========================================================
   // Software registers
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wdata_reg <= 32'h0000_0000;
         cfg_reg <= 5'h00;
      end else if (wr_in && addr_in == `SCP_H_WDATA) begin
         wdata_reg <= wdata_in;
      end else if (wr_in && addr_in == `SCP_H_CFG) begin
         cfg_reg <= wdata_in[4:0];
      end
   end

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_out <= 32'h0000_0000;
      end else if (rd_in) begin
         case (addr_in)
            `SCP_H_WDATA: rdata_out <= wdata_reg;
            `SCP_H_CFG: rdata_out <= {27'h0, cfg_reg};
            `SCP_H_RDATA: rdata_out <= rx_reg;
            `SCP_H_STATUS: rdata_out <=
               {31'h0, state_reg != scp_pkg::SCP_H_IDLE};
            default: rdata_out <= 32'h0000_0000;
         endcase
      end else begin
         rdata_out <= 32'h0000_0000;
      end
   end

   // Profile pins follow the configuration register
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         link.profile <= 3'h0;
      end else begin
         link.profile <= cfg_reg[4:2];
      end
   end

   // ==========================================================
   // Cycle engine
   // Only an abort is taken mid-frame; other commands, and any command during a strobe, are dropped.
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_reg <= scp_pkg::SCP_H_IDLE;
         link.sclk <= 1'b0;
         link.cs_n <= 1'b1;
         link.host_sdio_o <= 1'b0;
         link.host_sdio_oe <= 1'b0;
         link.io_reset <= 1'b0;
         link.io_update <= 1'b0;
         seq_reg <= '0;
         bit_reg <= 6'h0;
         div_reg <= 4'h0;
         cnt_reg <= 8'h00;
         rdcyc_reg <= 1'b0;
         rx_reg <= 32'h0000_0000;
      end else begin
         case (state_reg)
            scp_pkg::SCP_H_IDLE: begin
               if (wr_in && addr_in == `SCP_H_CMD) begin
                  if (wdata_in[`SCP_H_CMD_ABORT_BIT]) begin
                     link.io_reset <= 1'b1;
                     cnt_reg <= 8'(`SCP_ABORT_CYC - 1);
                     state_reg <= scp_pkg::SCP_H_PULSE;
                  end else if (wdata_in[`SCP_H_CMD_UPD_BIT]) begin
                     link.io_update <= 1'b1;
                     cnt_reg <= 8'(`SCP_UPD_CYC - 1);
                     state_reg <= scp_pkg::SCP_H_PULSE;
                  end else begin
                     // Whole frame: instruction then every byte
                     if (cfg_reg[`SCP_H_CFG_LSB_BIT]) begin
                        seq_reg <= {wdata_reg, instr};
                        link.host_sdio_o <= instr[0];
                     end else begin
                        seq_reg <= rev({instr, wdata_reg});
                        link.host_sdio_o <= instr[7];
                     end
                     link.host_sdio_oe <= 1'b1;
                     link.cs_n <= 1'b0;
                     rdcyc_reg <= wdata_in[`SCP_H_CMD_RD_BIT];
                     bit_reg <= 6'h0;
                     div_reg <= 4'h0;
                     state_reg <= scp_pkg::SCP_H_XFER;
                  end
               end
            end
            scp_pkg::SCP_H_XFER: begin
               div_reg <= div_reg + 4'h1;
               if (div_reg == 4'(HALF - 1)) begin
                  link.sclk <= 1'b1;
               end
               if (div_reg == 4'(2 * HALF - 1)) begin
                  // Sample late in the high phase: the device's bit
                  // needs its sync delay plus ours to arrive
                  link.sclk <= 1'b0;
                  div_reg <= 4'h0;
                  if (rdcyc_reg && bit_reg >= 6'd8) begin
                     rx_reg <= cfg_reg[`SCP_H_CFG_LSB_BIT] ?
                               {din, rx_reg[31:1]} : {rx_reg[30:0], din};
                  end
                  if (bit_reg == 6'(NBITS - 1)) begin
                     link.cs_n <= 1'b1;
                     link.host_sdio_oe <= 1'b0;
                     state_reg <= scp_pkg::SCP_H_IDLE;
                  end else begin
                     bit_reg <= bit_reg + 6'h1;
                     seq_reg <= seq_reg >> 1;
                     link.host_sdio_o <= seq_reg[1];
                     link.host_sdio_oe <= ~(rdcyc_reg && bit_reg >= 6'd7);
                  end
               end
               // Abort cuts the frame at once; these assignments win
               if (wr_in && addr_in == `SCP_H_CMD &&
                   wdata_in[`SCP_H_CMD_ABORT_BIT]) begin
                  link.io_reset <= 1'b1;
                  link.sclk <= 1'b0;
                  link.cs_n <= 1'b1;
                  link.host_sdio_oe <= 1'b0;
                  cnt_reg <= 8'(`SCP_ABORT_CYC - 1);
                  state_reg <= scp_pkg::SCP_H_PULSE;
               end
            end
            scp_pkg::SCP_H_PULSE: begin
               if (cnt_reg == 8'h00) begin
                  link.io_reset <= 1'b0;
                  link.io_update <= 1'b0;
                  state_reg <= scp_pkg::SCP_H_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
            default: begin
               state_reg <= scp_pkg::SCP_H_IDLE;
            end
         endcase
      end
   end
endmodule : scp_host

// file: rtl/scp_sync.sv
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes each bit is an independent level; no bus coherence implied.
`timescale 1ns/1ps

module scp_sync #(
   parameter int W = 1
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_reg;

   // ==========================================================
   // First flop feeds only the second
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         meta_reg <= '0;
         q_out <= '0;
      end else begin
         meta_reg <= d_in;
         q_out <= meta_reg;
      end
   end
endmodule : scp_sync

// file: verification/scp_monitor.sv
// Checker on the port's pins: framing, pin ownership and update strobe width.
// Assumes both ends share mclk_in and resetn_in.
`timescale 1ns/1ps

module scp_monitor (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic io_reset,
   input wire logic io_update,
   input wire logic host_sdio_oe,
   input wire logic dev_sdio_o,
   input wire logic dev_sdio_oe,
   input wire logic dev_sdo_o,
   input wire logic dev_sdo_oe
);
   logic sclk_d_reg;
   logic [5:0] rise_cnt_reg;

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);

   // ==========================================================
   // Rises per frame, cleared while deselected
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sclk_d_reg <= 1'b0;
         rise_cnt_reg <= 6'h00;
      end else begin
         sclk_d_reg <= sclk;
         if (cs_n) begin
            rise_cnt_reg <= 6'h00;
         end else if (sclk && !sclk_d_reg) begin
            rise_cnt_reg <= rise_cnt_reg + 6'h01;
         end
      end
   end

   // ==========================================================
   // Properties
   a_frame_len: assert property (
      $rose(cs_n) && !io_reset |-> rise_cnt_reg == 6'h28)
      else $error("frame length wrong");
   a_sclk_framed: assert property ($rose(sclk) |-> !cs_n)
      else $error("clock rise outside frame");
   a_no_contend: assert property (!(host_sdio_oe && dev_sdio_oe))
      else $error("both ends drive shared pin");
   a_one_output: assert property (!(dev_sdio_oe && dev_sdo_oe))
      else $error("both device outputs enabled");
   a_cs_float: assert property (
      cs_n [*5] |-> !dev_sdio_oe && !dev_sdo_oe)
      else $error("output driven while deselected");
   a_abort_float: assert property (
      $fell(io_reset) |-> !dev_sdio_oe && !dev_sdo_oe)
      else $error("output driven after abort");
   a_oe_start: assert property (
      $rose(dev_sdio_oe) || $rose(dev_sdo_oe) |-> !cs_n && !host_sdio_oe)
      else $error("device drive began too early");
   a_bit_steady: assert property (sclk && $past(sclk) |->
      (!dev_sdio_oe || $stable(dev_sdio_o)) &&
      (!dev_sdo_oe || $stable(dev_sdo_o)))
      else $error("read bit moved while clock high");
   a_upd_width: assert property ($rose(io_update) |-> io_update [*8])
      else $error("update strobe too short");
endmodule : scp_monitor

// file: verification/serial_config_port_tb.sv
// Bench: host and device joined by the pin interface; host driven
// through its register port. Assumes the host map of scp_defines.svh.
`timescale 1ns/1ps
`include "scp_defines.svh"

module serial_config_port_tb;
   logic mclk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [31:0] rdata_out;
   logic [4:0] cfg_addr_in = 5'h00;
   logic [31:0] cfg_data_out;
   logic update_out;
   logic [31:0] got;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;

   scp_if link ();
   scp_host scp_host_i (.mclk_in(mclk_in), .resetn_in(resetn_in),
      .link(link.host), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out));
   scp_device scp_device_i (.mclk_in(mclk_in), .resetn_in(resetn_in),
      .link(link.dev), .cfg_addr_in(cfg_addr_in),
      .cfg_data_out(cfg_data_out), .update_out(update_out));
   scp_monitor scp_monitor_i (.mclk_in(mclk_in), .resetn_in(resetn_in),
      .sclk(link.sclk), .cs_n(link.cs_n), .io_reset(link.io_reset),
      .io_update(link.io_update), .host_sdio_oe(link.host_sdio_oe),
      .dev_sdio_o(link.dev_sdio_o), .dev_sdio_oe(link.dev_sdio_oe),
      .dev_sdo_o(link.dev_sdo_o), .dev_sdo_oe(link.dev_sdo_oe));

   // ==========================================================
   // Clock and hang guard; a run needs well under 15000 cycles
   always #5 mclk_in = ~mclk_in;
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 40000) begin
         err_total++;
         summarize();
      end
   end

   // ==========================================================
   // Tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask : rd

   // Command, then poll busy under a bound
   task automatic run(input logic [31:0] cmd);
      int n;
      n = 0;
      wr(`SCP_H_CMD, cmd);
      got = 32'h1;
      while (got[0] !== 1'b0 && n < 2000) begin
         rd(`SCP_H_STATUS, got);
         n++;
      end
      chk(got, 32'h0);
   endtask : run

   task automatic put(input logic [4:0] a, input logic [31:0] d);
      wr(`SCP_H_WDATA, d);
      run(32'(a));
   endtask : put

   task automatic peek(input logic [4:0] a, input logic [31:0] exp);
      @(posedge mclk_in);
      cfg_addr_in <= a;
      repeat (2) @(posedge mclk_in);
      #1 chk(cfg_data_out, exp);
   endtask : peek

   // Pulse is one cycle wide, so watch every cycle
   task automatic upd_wait();
      int n;
      for (n = 0; n < 30; n++) begin
         @(posedge mclk_in);
         #1 if (update_out === 1'b1) break;
      end
      chk(32'(update_out), 32'h1);
   endtask : upd_wait

   task automatic summarize();
      if (err_total == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   // ==========================================================
   // Main sequence
   initial begin : main
      repeat (12) @(posedge mclk_in);
      resetn_in <= 1'b1;
      peek(5'h01, 32'h0);
      put(5'h01, 32'ha5c3_1e87);
      peek(5'h01, 32'h0);
      run(32'h100);
      peek(5'h01, 32'ha5c3_1e87);
      put(5'h01, 32'h0f1e_2d3c);
      run(32'h81);
      rd(`SCP_H_RDATA, got);
      chk(got, 32'ha5c3_1e87);
      run(32'h200);
      put(5'h02, 32'h8000_0001);
      // Cut a write of reg 2 after one whole byte and three bits
      wr(`SCP_H_WDATA, 32'h1122_3344);
      wr(`SCP_H_CMD, 32'h02);
      repeat (150) @(posedge mclk_in);
      run(32'h200);
      put(5'h04, 32'h6d4e_3b2a);
      run(32'h100);
      peek(5'h01, 32'h0f1e_2d3c);
      peek(5'h02, 32'h1100_0001);
      peek(5'h04, 32'h6d4e_3b2a);
      // Profile pins to five: the change itself must update
      put(5'h13, 32'h5a5a_c3c3);
      wr(`SCP_H_CFG, 32'h14);
      upd_wait();
      peek(5'h13, 32'h5a5a_c3c3);
      run(32'h8e);
      rd(`SCP_H_RDATA, got);
      chk(got, 32'h5a5a_c3c3);
      // Three-wire read back over the separate output
      put(5'h00, 32'h2);
      run(32'h100);
      wr(`SCP_H_CFG, 32'h16);
      run(32'he1);
      rd(`SCP_H_RDATA, got);
      chk(got, 32'h0f1e_2d3c);
      // Low bit first on both ends, instruction included
      put(5'h00, 32'h3);
      run(32'h100);
      wr(`SCP_H_CFG, 32'h17);
      put(5'h03, 32'h1234_80f7);
      run(32'h100);
      peek(5'h03, 32'h1234_80f7);
      run(32'h83);
      rd(`SCP_H_RDATA, got);
      chk(got, 32'h1234_80f7);
      rd(8'h20, got);
      chk(got, 32'h0);
      summarize();
   end
endmodule : serial_config_port_tb
